//--- led_ctrl_pkg.sv
// Package with constants and types for the LED string fault and supply optimizer block.
package led_ctrl_pkg;
	localparam int unsigned NUM_STRINGS       = 4;
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned STEP_HOLD_MS      = 4;
	localparam int unsigned STEP_HOLD_CYCLES  = (STEP_HOLD_MS * CLK_HZ) / 1000;
	localparam int unsigned SHORT_VERIFY_CYCLES = 16;
	localparam int unsigned CODE_W            = 8;
	localparam logic [7:0]  CODE_MAX          = 8'hff;
	localparam logic [7:0]  CODE_ZERO         = 8'h00;
	localparam logic [7:0]  BACKOFF_STEPS     = 8'h02;
	localparam int unsigned FULL_SCALE_NA     = 280500;
	localparam int unsigned STEP_NA           = 1100;
	localparam int unsigned OT_TRIP_C         = 135;
	localparam int unsigned OT_RELEASE_C      = 120;
	// Register offsets.
	localparam logic [7:0]  OFF_CONFIG        = 8'h02;
	localparam logic [7:0]  OFF_CURRENT       = 8'h0e;
	localparam logic [7:0]  OFF_OPT_CTRL      = 8'h11;
	localparam logic [7:0]  OFF_SHORT_FLAGS   = 8'h09;
	localparam logic [7:0]  OFF_OPEN_FLAGS    = 8'h0a;
	localparam logic [7:0]  OFF_CODE_A        = 8'h14;
	localparam logic [7:0]  OFF_CODE_B        = 8'h15;
	// Reset values.
	localparam logic [7:0]  RST_CONFIG        = 8'h0e;
	localparam logic [7:0]  RST_CURRENT       = 8'h7f;
	localparam logic [7:0]  RST_OPT_CTRL      = 8'h00;
	// Field positions in the configuration register.
	localparam int unsigned CFG_FOLDBACK_BIT  = 7;
	localparam int unsigned CFG_SHORT_EN_BIT  = 3;
	localparam int unsigned CFG_OPEN_EN_BIT   = 2;
	localparam int unsigned CFG_OPT_EN_BIT    = 1;

	// Optimizer states.
	typedef enum logic [4:0] {
		OPT_IDLE  = 5'b00001,
		OPT_CAL   = 5'b00010,
		OPT_RUN   = 5'b00100,
		OPT_RAISE = 5'b01000,
		OPT_FORCE = 5'b10000
	} opt_state_e;

	// Register bus request.
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Per-string inputs from the analog front end.
	typedef struct packed {
		logic [3:0] short_ind;
		logic [3:0] in_reg;
	} str_sense_s;
endpackage

//--- led_string_fault_and_supply_optimizer.sv
// LED string fault handling, supply optimizer and over-temperature reset control.
// Notes on behaviour
// - Any verified short or open fault drives the open-drain fault output low.
// - A verified short disables the string and drops it from optimizer monitoring.
// - Drain node above 5.9V, flagged by comparator, counts as a short indication.
// - With fold-back enabled, current is reduced as soon as a short is seen.
// - Loss of regulation makes the optimizer raise supply step by step to maximum.
// - At maximum supply, unregulated strings become open faults, then recalibrate.
// - Enable low then high clears all faults and resumes control of strings.
// - Each faulty string is recorded in a host readable flag.
// - Over-temperature above 135C holds the device in reset until below 120C.
// - In over-temperature reset registers return to defaults and the bus is off.
// - Calibration starts at power-up and at each rising edge of enable.
// - Calibration raises the code one step, waits the hold time, rechecks regulation.
// - On regulation error the code backs off slightly and calibration ends.
// - Each output sources a feedback current from zero to 280.5 microamps.
// - Strings 0 and 1 belong to output a, strings 2 and 3 to output b.
// - Default step hold is 4ms with a step of 1.1 microamps.
// - A cascade input from an upstream optimizer is combined with local demand.
// - When both strings of one optimizer fault, that output forces maximum supply.
// - The eight-bit global current setting resets to 127.
// - Enable low releases the fault output and restores register defaults.
`timescale 1ns/1ps
module led_string_fault_and_supply_optimizer #(
	parameter int unsigned HOLD_CYCLES   = led_ctrl_pkg::STEP_HOLD_CYCLES,
	parameter int unsigned VERIFY_CYCLES = led_ctrl_pkg::SHORT_VERIFY_CYCLES
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     enable,
	input  wire logic                     over_temp_hi,
	input  wire logic                     over_temp_lo,
	input  wire led_ctrl_pkg::str_sense_s sense,
	input  wire logic [1:0]               cascade_feedback_in,
	input  wire logic                     reg_valid,
	input  wire led_ctrl_pkg::reg_req_s   reg_req,
	output logic [7:0]                    reg_rdata,
	output logic                          bus_enabled,
	output logic                          fault_out_n_oe,
	output logic                          fault_out_n,
	output logic [3:0]                    string_on,
	output logic                          foldback,
	output logic [7:0]                    global_string_current,
	output logic [7:0]                    supply_feedback_out_a,
	output logic [7:0]                    supply_feedback_out_b,
	output logic [1:0]                    supply_feedback_out
);
	// Refuses timing values that the counters below cannot serve.
	if (HOLD_CYCLES < 1 || VERIFY_CYCLES < 1 || VERIFY_CYCLES > 65535) begin : g_bad_timing
		$error("Unsupported timing parameters.");
	end

	// Clamped step of a feedback code; up means less supply voltage.
	function automatic logic [7:0] step_code(input logic [7:0] c, input logic up,
		input logic [7:0] n);
		logic [8:0] s;
		s = 9'h000;
		if (up)
			s = {1'b0, c} + {1'b0, n};
		else
			s = {1'b0, c} - {1'b0, n};
		if (up && s[8])
			step_code = led_ctrl_pkg::CODE_MAX;
		else if (!up && s[8])
			step_code = led_ctrl_pkg::CODE_ZERO;
		else
			step_code = s[7:0];
	endfunction

	logic       en_q, en_d;
	logic       ot_q, ot_d;
	logic       hold_rst;
	logic       start_cal;
	logic [7:0] cfg_q, cfg_d, cur_q, cur_d, octl_q, octl_d;
	logic [3:0] sc_q, sc_d, oc_q, oc_d;
	logic [15:0] vcnt_q [4];
	logic [15:0] vcnt_d [4];
	logic [3:0] faulted;

	// Over-temperature hysteresis and enable edge tracking.
	always_comb begin
		ot_d = ot_q;
		if (over_temp_hi)
			ot_d = 1'b1;
		else if (!over_temp_lo)
			ot_d = 1'b0;
		en_d = enable;
	end
	assign hold_rst  = rst || ot_q || !enable;
	assign start_cal = enable && !en_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ot_q <= 1'b0;
			en_q <= 1'b0;
		end else begin
			ot_q <= ot_d;
			en_q <= en_d;
		end
	end

	// Register writes; everything reverts while held in reset.
	always_comb begin
		cfg_d  = cfg_q;
		cur_d  = cur_q;
		octl_d = octl_q;
		if (reg_valid && reg_req.wr) begin
			case (reg_req.addr)
				led_ctrl_pkg::OFF_CONFIG:   cfg_d = reg_req.wdata;
				led_ctrl_pkg::OFF_CURRENT:  cur_d = reg_req.wdata;
				led_ctrl_pkg::OFF_OPT_CTRL: octl_d = reg_req.wdata;
				default: cfg_d = cfg_q;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (hold_rst) begin
			cfg_q  <= led_ctrl_pkg::RST_CONFIG;
			cur_q  <= led_ctrl_pkg::RST_CURRENT;
			octl_q <= led_ctrl_pkg::RST_OPT_CTRL;
		end else begin
			cfg_q  <= cfg_d;
			cur_q  <= cur_d;
			octl_q <= octl_d;
		end
	end

	// Read mux; unmapped reads return zero.
	always_comb begin
		case (reg_req.addr)
			led_ctrl_pkg::OFF_CONFIG:      reg_rdata = cfg_q;
			led_ctrl_pkg::OFF_CURRENT:     reg_rdata = cur_q;
			led_ctrl_pkg::OFF_OPT_CTRL:    reg_rdata = octl_q;
			led_ctrl_pkg::OFF_SHORT_FLAGS: reg_rdata = {4'h0, sc_q};
			led_ctrl_pkg::OFF_OPEN_FLAGS:  reg_rdata = {4'h0, oc_q};
			led_ctrl_pkg::OFF_CODE_A:      reg_rdata = supply_feedback_out_a;
			led_ctrl_pkg::OFF_CODE_B:      reg_rdata = supply_feedback_out_b;
			default:                       reg_rdata = 8'h00;
		endcase
	end

	logic       open_declare;
	logic [3:0] open_mask;

	// Short verification counters and fault flags.
	always_comb begin
		sc_d = sc_q;
		oc_d = oc_q;
		for (int i = 0; i < 4; i++) begin
			vcnt_d[i] = 16'h0000;
			if (sense.short_ind[i] && string_on[i] && cfg_q[led_ctrl_pkg::CFG_SHORT_EN_BIT]) begin
				vcnt_d[i] = vcnt_q[i] + 16'h0001;
				if (vcnt_q[i] == 16'(VERIFY_CYCLES - 1))
					sc_d[i] = 1'b1;
			end
		end
		if (open_declare && cfg_q[led_ctrl_pkg::CFG_OPEN_EN_BIT])
			oc_d = oc_q | open_mask;
	end
	always_ff @(posedge core_clk) begin
		if (hold_rst) begin
			sc_q <= 4'h0;
			oc_q <= 4'h0;
			for (int i = 0; i < 4; i++)
				vcnt_q[i] <= 16'h0000;
		end else begin
			sc_q <= sc_d;
			oc_q <= oc_d;
			for (int i = 0; i < 4; i++)
				vcnt_q[i] <= vcnt_d[i];
		end
	end
	assign faulted        = sc_q | oc_q;
	assign string_on      = hold_rst ? 4'h0 : ~faulted;
	assign fault_out_n    = 1'b0;
	assign fault_out_n_oe = !hold_rst && (faulted != 4'h0);
	assign foldback       = cfg_q[led_ctrl_pkg::CFG_FOLDBACK_BIT] && ((sense.short_ind & string_on) != 4'h0);
	assign global_string_current = cur_q;
	assign bus_enabled    = !ot_q;

	// Two optimizer channels, one per supply.
	led_ctrl_pkg::opt_state_e st_q [2];
	led_ctrl_pkg::opt_state_e st_d [2];
	logic [7:0] code_q [2];
	logic [7:0] code_d [2];
	logic [31:0] hcnt_q [2];
	logic [31:0] hcnt_d [2];
	logic [1:0] demand;
	logic [1:0] open_fire;

	// Stepping sequence for each channel.
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			logic [1:0] mine;
			logic       reg_ok;
			logic       tick;
			mine      = faulted[2*k +: 2];
			reg_ok    = ((~sense.in_reg[2*k +: 2] & ~mine) == 2'b00) && !cascade_feedback_in[k];
			st_d[k]   = st_q[k];
			code_d[k] = code_q[k];
			hcnt_d[k] = hcnt_q[k] + 32'h1;
			tick      = hcnt_q[k] >= 32'(HOLD_CYCLES - 1);
			open_fire[k] = 1'b0;
			demand[k] = !reg_ok;
			if (tick)
				hcnt_d[k] = 32'h0;
			case (st_q[k])
				led_ctrl_pkg::OPT_IDLE: begin
					hcnt_d[k] = 32'h0;
					if (cfg_q[led_ctrl_pkg::CFG_OPT_EN_BIT])
						st_d[k] = led_ctrl_pkg::OPT_CAL;
				end
				led_ctrl_pkg::OPT_CAL: if (tick) begin
					if (reg_ok && code_q[k] != led_ctrl_pkg::CODE_MAX)
						code_d[k] = step_code(code_q[k], 1'b1, 8'h01);
					else if (!reg_ok) begin
						code_d[k] = step_code(code_q[k], 1'b0, led_ctrl_pkg::BACKOFF_STEPS);
						st_d[k] = led_ctrl_pkg::OPT_RUN;
					end
				end
				led_ctrl_pkg::OPT_RUN: if (!reg_ok)
					st_d[k] = led_ctrl_pkg::OPT_RAISE;
				led_ctrl_pkg::OPT_RAISE: if (tick) begin
					if (reg_ok)
						st_d[k] = led_ctrl_pkg::OPT_RUN;
					else if (code_q[k] == led_ctrl_pkg::CODE_ZERO) begin
						open_fire[k] = 1'b1;
						st_d[k] = led_ctrl_pkg::OPT_CAL;
					end else
						code_d[k] = step_code(code_q[k], 1'b0, 8'h01);
				end
				led_ctrl_pkg::OPT_FORCE: code_d[k] = led_ctrl_pkg::CODE_ZERO;
				default: st_d[k] = led_ctrl_pkg::OPT_IDLE;
			endcase
			if (mine == 2'b11) begin
				st_d[k] = led_ctrl_pkg::OPT_FORCE;
				code_d[k] = led_ctrl_pkg::CODE_ZERO;
			end
		end
	end
	assign open_declare = open_fire != 2'b00;
	// Strings already faulted are off and out of regulation; they are not declared open again.
	assign open_mask = {{2{open_fire[1]}} & ~sense.in_reg[3:2] & ~faulted[3:2],
		{2{open_fire[0]}} & ~sense.in_reg[1:0] & ~faulted[1:0]};
	always_ff @(posedge core_clk) begin
		for (int k = 0; k < 2; k++) begin
			if (hold_rst || start_cal) begin
				st_q[k]   <= led_ctrl_pkg::OPT_IDLE;
				code_q[k] <= led_ctrl_pkg::CODE_ZERO;
				hcnt_q[k] <= 32'h0;
			end else begin
				st_q[k]   <= st_d[k];
				code_q[k] <= code_d[k];
				hcnt_q[k] <= hcnt_d[k];
			end
		end
	end
	assign supply_feedback_out_a = code_q[0];
	assign supply_feedback_out_b = code_q[1];
	assign supply_feedback_out   = demand;

	property p_fault_pin;
		@(posedge core_clk) disable iff (rst)
		(faulted != 4'h0 && !hold_rst) |-> fault_out_n_oe;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("Fault output not asserted.");
	property p_short_off;
		@(posedge core_clk) disable iff (rst)
		(sc_q != 4'h0) |-> ((string_on & sc_q) == 4'h0);
	endproperty
	a_short_off: assert property (p_short_off) else $error("Shorted string still on.");
	property p_current_rst;
		@(posedge core_clk) disable iff (rst)
		$past(hold_rst) |-> global_string_current == 8'h7f;
	endproperty
	a_current_rst: assert property (p_current_rst) else $error("Current not at default.");
	property p_release;
		@(posedge core_clk) disable iff (rst)
		!enable |-> !fault_out_n_oe && string_on == 4'h0;
	endproperty
	a_release: assert property (p_release) else $error("Fault not released.");
	property p_ot_bus;
		@(posedge core_clk) disable iff (rst)
		$past(over_temp_hi) |-> !bus_enabled;
	endproperty
	a_ot_bus: assert property (p_ot_bus) else $error("Bus active in over-temp.");
	property p_force;
		@(posedge core_clk) disable iff (rst)
		(faulted[1:0] == 2'b11 && !hold_rst && !start_cal) |=> supply_feedback_out_a == 8'h00;
	endproperty
	a_force: assert property (p_force) else $error("Supply not forced to maximum.");
	property p_foldback;
		@(posedge core_clk) disable iff (rst)
		(cfg_q[7] && sense.short_ind[0] && string_on[0]) |-> foldback;
	endproperty
	a_foldback: assert property (p_foldback) else $error("Fold-back missed.");
	property p_step_size;
		@(posedge core_clk) disable iff (rst || hold_rst || start_cal)
		(st_q[0] == led_ctrl_pkg::OPT_CAL && st_d[0] == led_ctrl_pkg::OPT_CAL
			&& code_d[0] != code_q[0]) |=>
			supply_feedback_out_a == $past(code_q[0]) + 8'h01;
	endproperty
	a_step_size: assert property (p_step_size) else $error("Wrong calibration step.");
	c_short: cover property (@(posedge core_clk) $rose(sc_q != 4'h0));
	c_open: cover property (@(posedge core_clk) $rose(oc_q != 4'h0));
	c_run: cover property (@(posedge core_clk) st_q[0] == led_ctrl_pkg::OPT_RUN);
endmodule

//--- supply_partner.sv
// Behavioural model of the string supplies and current-sink transistors.
`timescale 1ns/1ps
module supply_partner #(
	parameter logic [7:0] LIMIT = 8'h20
) (
	input  wire logic [7:0]          code_a,
	input  wire logic [7:0]          code_b,
	input  wire logic [3:0]          string_on,
	input  wire logic [3:0]          open_mask,
	input  wire logic [3:0]          short_mask,
	output led_ctrl_pkg::str_sense_s sense
);
	// A string regulates only while driven, closed, and its supply code leaves enough voltage.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sense.in_reg[i] = string_on[i] && !open_mask[i]
				&& (((i < 2) ? code_a : code_b) <= LIMIT);
			sense.short_ind[i] = short_mask[i] && string_on[i];
		end
	end
endmodule

//--- led_string_fault_and_supply_optimizer_tb.sv
// Self-checking testbench for the LED string fault and supply optimizer block.
`timescale 1ns/1ps
module led_string_fault_and_supply_optimizer_tb;
	localparam logic [7:0] LIMIT = 8'h20;
	logic                    core_clk, rst, enable, over_temp_hi, over_temp_lo, reg_valid;
	logic [1:0]              casc;
	logic [3:0]              open_mask, short_mask, string_on;
	led_ctrl_pkg::reg_req_s  reg_req;
	led_ctrl_pkg::str_sense_s sense;
	logic [7:0]              reg_rdata, cur, code_a, code_b;
	logic                    bus_enabled, flt_oe, flt, foldback;
	logic [1:0]              fb_out;
	int                      n_mismatch, checks;

	led_string_fault_and_supply_optimizer #(.HOLD_CYCLES(4), .VERIFY_CYCLES(16)) u_dut (
		.core_clk(core_clk), .rst(rst), .enable(enable), .over_temp_hi(over_temp_hi),
		.over_temp_lo(over_temp_lo), .sense(sense), .cascade_feedback_in(casc),
		.reg_valid(reg_valid), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.bus_enabled(bus_enabled), .fault_out_n_oe(flt_oe), .fault_out_n(flt),
		.string_on(string_on), .foldback(foldback), .global_string_current(cur),
		.supply_feedback_out_a(code_a), .supply_feedback_out_b(code_b),
		.supply_feedback_out(fb_out));

	supply_partner #(.LIMIT(LIMIT)) u_partner (
		.code_a(code_a), .code_b(code_b), .string_on(string_on),
		.open_mask(open_mask), .short_mask(short_mask), .sense(sense));

	// Free-running clock at 10 MHz.
	always #50 core_clk = ~core_clk;

	// Compares a seen value against the expected one and records the outcome.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Advances to just after the n-th next rising edge.
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Register write, taken at the next rising edge; valid stays up when another write follows.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic last);
		reg_req = '{1'b1, a, d};
		reg_valid = 1'b1;
		step(1);
		if (last)
			reg_valid = 1'b0;
	endtask

	// Combinational register read compared against an expected value.
	task automatic chk_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
		reg_req = '{1'b0, a, 8'h00};
		#1;
		check(name, reg_rdata, exp);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Waits for a string to be switched off, bounded.
	task automatic wait_off(input int s);
		for (int i = 0; i < 3000 && string_on[s] !== 1'b0; i++)
			step(1);
	endtask

	// Reset defaults, writes, back-to-back writes and an unmapped place.
	task automatic t_regs();
		chk_reg("current reset", 8'h0e, 8'h7f);
		chk_reg("config reset", 8'h02, led_ctrl_pkg::RST_CONFIG);
		chk_reg("opt ctrl reset", 8'h11, 8'h00);
		check("fault pin idle", {6'h00, flt_oe, flt}, 8'h00);
		wr(8'h0e, 8'ha5, 1'b0);
		wr(8'h0e, 8'h5a, 1'b0);
		wr(8'h01, 8'h33, 1'b1);
		chk_reg("current written", 8'h0e, 8'h5a);
		check("current output", cur, 8'h5a);
		chk_reg("unmapped", 8'h01, 8'h00);
		$display("test regs done");
	endtask

	// A brief short is ignored; a persisting short is latched and flagged.
	task automatic t_short();
		wr(8'h02, 8'h8e, 1'b1);
		short_mask = 4'h2;
		step(2);
		check("foldback on live short", {7'h00, foldback}, 8'h01);
		step(10);
		short_mask = 4'h0;
		step(2);
		check("brief short ignored", {4'h0, string_on}, 8'h0f);
		short_mask = 4'h2;
		step(24);
		short_mask = 4'h0;
		step(1);
		check("short string off", {4'h0, string_on}, 8'h0d);
		check("fault pin low", {7'h00, flt_oe}, 8'h01);
		chk_reg("short flags", 8'h09, 8'h02);
		$display("test short done");
	endtask

	// Enable low then high clears faults and restores defaults.
	task automatic t_enable();
		enable = 1'b0;
		step(3);
		check("fault released", {7'h00, flt_oe}, 8'h00);
		enable = 1'b1;
		step(2);
		check("strings resumed", {4'h0, string_on}, 8'h0f);
		chk_reg("short flags cleared", 8'h09, 8'h00);
		chk_reg("config default", 8'h02, led_ctrl_pkg::RST_CONFIG);
		chk_reg("current default", 8'h0e, 8'h7f);
		$display("test enable done");
	endtask

	// Calibration walks each code to the regulation edge and backs off.
	task automatic t_cal();
		step(800);
		check("code a window", {7'h00, code_a <= LIMIT && code_a >= LIMIT - 8'h03}, 8'h01);
		check("code b window", {7'h00, code_b <= LIMIT && code_b >= LIMIT - 8'h03}, 8'h01);
		// The code climbs one past the regulation edge, then backs off.
		chk_reg("code a readback", 8'h14, LIMIT + 8'h01 - led_ctrl_pkg::BACKOFF_STEPS);
		chk_reg("code b readback", 8'h15, LIMIT + 8'h01 - led_ctrl_pkg::BACKOFF_STEPS);
		check("no demand settled", {6'h00, fb_out}, 8'h00);
		// An upstream demand on channel a is passed on and raises its supply.
		casc = 2'b01;
		step(1);
		check("cascade demand", {6'h00, fb_out}, 8'h01);
		step(9);
		check("cascade raises a", {7'h00, code_a < LIMIT - 8'h01}, 8'h01);
		casc = 2'b00;
		$display("test calibration done");
	endtask

	// Open string found at maximum supply; then both strings of b faulted.
	task automatic t_open();
		open_mask = 4'h4;
		wait_off(2);
		check("max supply at open", code_b, 8'h00);
		check("open string off", {4'h0, string_on}, 8'h0b);
		check("fault pin on open", {7'h00, flt_oe}, 8'h01);
		chk_reg("open flags", 8'h0a, 8'h04);
		step(800);
		check("recalibrated b", {7'h00, code_b <= LIMIT && code_b >= LIMIT - 8'h03}, 8'h01);
		open_mask = 4'hc;
		wait_off(3);
		step(20);
		check("b forced to max", code_b, 8'h00);
		$display("test open done");
	endtask

	// Over-temperature holds reset until the lower threshold clears.
	task automatic t_temp();
		wr(8'h0e, 8'h44, 1'b1);
		over_temp_hi = 1'b1;
		over_temp_lo = 1'b1;
		step(3);
		check("bus off hot", {7'h00, bus_enabled}, 8'h00);
		check("strings off hot", {4'h0, string_on}, 8'h00);
		over_temp_hi = 1'b0;
		step(3);
		check("held until cool", {7'h00, bus_enabled}, 8'h00);
		over_temp_lo = 1'b0;
		step(3);
		check("bus back", {7'h00, bus_enabled}, 8'h01);
		chk_reg("current after hot", 8'h0e, 8'h7f);
		$display("test temperature done");
	endtask

	// Cuts a hung run short.
	initial begin
		#(20000 * 100);
		n_mismatch++;
		give_verdict();
	end

	// Main sequence.
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		enable = 1'b1;
		{over_temp_hi, over_temp_lo, reg_valid} = 3'b000;
		casc = 2'b00;
		open_mask = 4'h0;
		short_mask = 4'h0;
		reg_req = '{1'b0, 8'h00, 8'h00};
		n_mismatch = 0;
		checks = 0;
		step(8);
		rst = 1'b0;
		t_regs();
		t_short();
		t_enable();
		t_cal();
		t_open();
		open_mask = 4'h0;
		t_temp();
		give_verdict();
	end
endmodule
